// ===== common/ism_pkg.sv
package ism_pkg;

    // array geometry and latch values
    localparam int          ADDR_W    = 17;
    localparam int          MEM_DEPTH = 131072;
    localparam logic [16:0] ADDR_RST  = 17'h00000;
    localparam logic [16:0] ADDR_TOP  = 17'h1ffff;

    // slave address fields
    localparam logic [3:0]  DEV_TYPE  = 4'ha;
    localparam logic [4:0]  HS_CODE   = 5'h01;

    // bit counter within a nine-clock byte slot
    localparam logic [3:0]  CNT_RST   = 4'h0;
    localparam logic [3:0]  CNT_FIRST = 4'h1;
    localparam logic [3:0]  BIT_LAST  = 4'h7;
    localparam logic [3:0]  BIT_ACK   = 4'h8;
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [1:0]  SEL_RST   = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SLV,
        ST_ADH,
        ST_ADL,
        ST_WDATA,
        ST_RDATA
    } ism_state_t;

    // next latch value, wrapping at the top of the array
    function automatic logic [16:0] ism_addr_next(input logic [16:0] a);
        return (a == ADDR_TOP) ? ADDR_RST : a + 17'h00001;
    endfunction

endpackage

// ===== design/ism_slave.sv
// Summary of operation
// (R1) 17-bit latch, page bit on top, one byte per address.
// (R2) writes finish within the bit clock; never busy to the bus.
// (R3) master makes the serial clock; this end only listens to it.
// (R4) data rising with clock high is stop; it aborts everything.
// (R5) data falling with clock high is start; it restarts decoding.
// (R6) master changes data only while clock low, except start and stop.
// (R7) after eight bits transmitter releases data; receiver pulls low to acknowledge.
// (R8) no acknowledge aborts the operation; device waits to be addressed.
// (R9) reads continue while master acknowledges; master leaves last byte unacknowledged.
// (R10) first byte after start is slave address; upper nibble must be type code.
// (R11) address bits three and two must match the select pins.
// (R12) address bit one is the top memory address bit.
// (R13) address bit zero: one reads, zero writes.
// (R14) master code 00001xxx enters high-speed mode.
// (R15) stop leaves high-speed mode; transfers work unchanged in it.
// (R16) writes take two address bytes, joined with page bit into the latch.
// (R17) reads start at the latch, kept until reloaded.
// (R18) latch increments before each data acknowledge, wrapping to zero.
// (R19) no limit on bytes per read or write.
// (R20) read: send eight bits, sample acknowledge, continue or release.
// (R21) write: take eight bits, then drive acknowledge.
// (R22) every byte moves most significant bit first.
// (R23) write protect high: data bytes not acknowledged, latch not incremented.
// (R24) byte committed after its eighth bit; earlier start or stop discards it.
// (R25) random read: write address, repeated start, then read direction.
// (R26) mismatched address: data line released until next start.
module ism_slave
    import ism_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic [1:0] device_select_pins,
    input  wire logic       write_protect,
    output logic            hs_mode,
    output logic            bus_busy
);

    // start and stop toggles, clocked by the data line
    logic             start_tgl;
    logic             stop_tgl;

    // link domain state, clocked by scl
    logic             start_ack;
    logic             stop_ack;
    ism_state_t       state;
    ism_state_t       nxt_state;
    logic [3:0]       cnt;
    logic [7:0]       rx;
    logic [7:0]       tx;
    logic [16:0]      addr;
    logic [7:0]       addr_hi;
    logic             page;
    logic             ack_en;
    logic             hs;
    logic             wp_meta;
    logic             wp_sync;
    logic [1:0]       sel_meta;
    logic [1:0]       sel_sync;
    logic [7:0]       mem [0:MEM_DEPTH-1];

    // next values
    ism_state_t       next_state;
    ism_state_t       next_nxt;
    logic [3:0]       next_cnt;
    logic [7:0]       next_rx;
    logic [7:0]       next_tx;
    logic [16:0]      next_addr;
    logic [7:0]       next_hi;
    logic             next_page;
    logic             next_ack;
    logic             next_hs;
    logic             next_oe;

    // system clock side
    logic [1:0]       stat_meta;
    logic [1:0]       stat_sync;

    // decode wires
    wire logic        new_start = start_tgl ^ start_ack;
    wire logic        stop_pend = stop_tgl ^ stop_ack;
    wire logic [7:0]  rx_byte   = {rx[6:0], sda_i};
    wire logic        is_hs     = (rx_byte[7:3] == HS_CODE);
    wire logic        type_ok   = (rx_byte[7:4] == DEV_TYPE);
    wire logic        sel_ok    = (rx_byte[3:2] == sel_sync);
    wire logic        is_me     = type_ok && sel_ok;
    wire logic        rx_state  = (state == ST_SLV) || (state == ST_ADH) ||
                                  (state == ST_ADL) || (state == ST_WDATA);
    wire logic        tx_bit    = tx[~cnt[2:0]];
    wire logic [7:0]  mem_rd    = mem[addr];
    wire logic        mem_we    = !new_start && !stop_pend && (state == ST_WDATA) &&
                                  (cnt == BIT_LAST) && !wp_sync;
    wire logic        hs_lvl    = hs && !stop_pend;
    wire logic        busy_lvl  = (state != ST_IDLE) && !stop_pend;

    // (R5) start: data falls while clock high
    always_ff @(negedge sda_i or negedge rst_n) begin
        if (!rst_n) begin
            start_tgl <= 1'b0;
        end else if (scl) begin
            start_tgl <= ~start_tgl;
        end
    end

    // (R4) stop: data rises while clock high
    // caught on the data line since scl may stay idle after a stop
    always_ff @(posedge sda_i or negedge rst_n) begin
        if (!rst_n) begin
            stop_tgl <= 1'b0;
        end else if (scl) begin
            stop_tgl <= ~stop_tgl;
        end
    end

    // strap-like pins resynchronised onto the link clock
    always_ff @(posedge scl or negedge rst_n) begin
        if (!rst_n) begin
            wp_meta  <= 1'b0;
            wp_sync  <= 1'b0;
            sel_meta <= SEL_RST;
            sel_sync <= SEL_RST;
        end else begin
            wp_meta  <= write_protect;
            wp_sync  <= wp_meta;
            sel_meta <= device_select_pins;
            sel_sync <= sel_meta;
        end
    end

    // protocol decode for each rising scl edge
    always_comb begin
        next_state = state;
        next_nxt   = nxt_state;
        next_cnt   = cnt;
        next_rx    = rx;
        next_tx    = tx;
        next_addr  = addr;
        next_hi    = addr_hi;
        next_page  = page;
        next_ack   = ack_en;
        next_hs    = hs;
        // (R15) stop leaves high-speed mode
        if (stop_pend) begin
            next_hs = 1'b0;
        end
        if (new_start) begin
            // (R10) first bit of the slave address byte
            next_state = ST_SLV;
            next_cnt   = CNT_FIRST;
            next_rx    = {7'h00, sda_i};
            next_ack   = 1'b0;
        end else if (stop_pend) begin
            // (R4) stop aborts the operation
            next_state = ST_IDLE;
            next_ack   = 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // (R26) ignore traffic until the next start
                    next_cnt = CNT_RST;
                end
                ST_RDATA: begin
                    if (cnt == BIT_ACK) begin
                        // (R20) acknowledge sampled: next byte or finish
                        if (!sda_i) begin
                            next_tx  = mem_rd;
                            next_cnt = CNT_RST;
                        end else begin
                            // (R8) no acknowledge ends the read
                            next_state = ST_IDLE;
                        end
                    end else if (cnt == BIT_LAST) begin
                        // (R18) advance before the acknowledge slot
                        next_addr = ism_addr_next(addr);
                        next_cnt  = BIT_ACK;
                    end else begin
                        next_cnt = cnt + CNT_FIRST;
                    end
                end
                default: begin
                    if (cnt == BIT_ACK) begin
                        // (R8) unacknowledged byte returns to idle
                        next_cnt   = CNT_RST;
                        next_state = ack_en ? nxt_state : ST_IDLE;
                        // (R17) read begins at the current latch
                        if (ack_en && (nxt_state == ST_RDATA)) begin
                            next_tx = mem_rd;
                        end
                    end else if (cnt == BIT_LAST) begin
                        // (R22) byte complete, msb arrived first
                        next_rx  = rx_byte;
                        next_cnt = BIT_ACK;
                        next_ack = 1'b0;
                        case (state)
                            ST_SLV: begin
                                if (is_hs) begin
                                    // (R14) master code, not acknowledged
                                    next_hs  = 1'b1;
                                    next_nxt = ST_IDLE;
                                end else if (is_me) begin
                                    // (R11) (R12) (R13) select, page, direction
                                    next_ack  = 1'b1;
                                    next_page = rx_byte[1];
                                    next_nxt  = rx_byte[0] ? ST_RDATA : ST_ADH;
                                end else begin
                                    next_nxt = ST_IDLE;
                                end
                            end
                            ST_ADH: begin
                                // (R16) high address byte
                                next_hi  = rx_byte;
                                next_ack = 1'b1;
                                next_nxt = ST_ADL;
                            end
                            ST_ADL: begin
                                // (R1) (R16) page bit joins the two bytes
                                next_addr = {page, addr_hi, rx_byte};
                                next_ack  = 1'b1;
                                next_nxt  = ST_WDATA;
                            end
                            default: begin
                                // (R23) protected data is refused, latch held
                                next_ack = !wp_sync;
                                next_nxt = ST_WDATA;
                                if (!wp_sync) begin
                                    next_addr = ism_addr_next(addr);
                                end
                            end
                        endcase
                    end else begin
                        next_rx  = rx_byte;
                        next_cnt = cnt + CNT_FIRST;
                    end
                end
            endcase
        end
    end

    // link state registers
    always_ff @(posedge scl or negedge rst_n) begin
        if (!rst_n) begin
            start_ack <= 1'b0;
            stop_ack  <= 1'b0;
            state     <= ST_IDLE;
            nxt_state <= ST_IDLE;
            cnt       <= CNT_RST;
            rx        <= BYTE_RST;
            tx        <= BYTE_RST;
            addr      <= ADDR_RST;
            addr_hi   <= BYTE_RST;
            page      <= 1'b0;
            ack_en    <= 1'b0;
            hs        <= 1'b0;
        end else begin
            start_ack <= start_tgl;
            stop_ack  <= stop_tgl;
            state     <= next_state;
            nxt_state <= next_nxt;
            cnt       <= next_cnt;
            rx        <= next_rx;
            tx        <= next_tx;
            addr      <= next_addr;
            addr_hi   <= next_hi;
            page      <= next_page;
            ack_en    <= next_ack;
            hs        <= next_hs;
        end
    end

    // (R2) (R24) array commit on the eighth bit, inside one bit time
    // (R19) no page buffer, so no length limit
    always_ff @(posedge scl) begin
        if (mem_we) begin
            mem[addr] <= rx_byte;
        end
    end

    // (R7) drive low for our acknowledge or a zero read bit
    // start or stop pending releases the line at the next falling scl edge (R26)
    assign next_oe = !new_start && !stop_pend &&
                     ((rx_state && (cnt == BIT_ACK) && ack_en) ||
                      ((state == ST_RDATA) && (cnt <= BIT_LAST) && !tx_bit));

    // (R20) data changes on the falling edge; (R9) release in ack slot
    always_ff @(negedge scl or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= next_oe;
        end
    end

    // status levels cross into the system clock by two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_meta <= 2'h0;
            stat_sync <= 2'h0;
            sda_o     <= 1'b0;
        end else begin
            stat_meta <= {hs_lvl, busy_lvl};
            stat_sync <= stat_meta;
            sda_o     <= 1'b0; // open drain: only ever pulls low
        end
    end

    assign hs_mode  = stat_sync[1];
    assign bus_busy = stat_sync[0];

endmodule

// ===== tb/ism_chk.sv
module ism_chk
    import ism_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       scl,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic [1:0] device_select_pins,
    input wire logic       write_protect,
    input wire logic       hs_mode,
    input wire logic       bus_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       st_t, st_q, sp_t, wr, rd, quiet, oe_r;
    logic [2:0] sp_s;
    logic [3:0] cnt;
    logic [1:0] nb;
    logic [7:0] sh;
    wire nf  = st_t != st_q;
    wire ack = cnt == 4'h8 && !nf;
    wire hit = sh[7:4] == DEV_TYPE && sh[3:2] == device_select_pins;
    // frame edges as toggles, so both clock domains can pick them up
    always_ff @(negedge sda_i or negedge rst_n)
        if (!rst_n) st_t <= 1'b0;
        else if (scl) st_t <= ~st_t;
    always_ff @(posedge sda_i or negedge rst_n)
        if (!rst_n) sp_t <= 1'b0;
        else if (scl) sp_t <= ~sp_t;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) sp_s <= '0;
        else sp_s <= {sp_s[1:0], sp_t};
    // shadow of bit slot, byte index and transfer kind
    always_ff @(posedge scl or negedge rst_n) begin
        if (!rst_n) begin
            {st_q, cnt, nb, sh, wr, rd, quiet, oe_r} <= '0;
        end else begin
            st_q <= st_t;
            sh   <= {sh[6:0], sda_i};
            oe_r <= sda_oe;
            cnt  <= (nf || cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
            if (nf) begin
                {nb, wr, rd, quiet} <= '0;
            end else if (ack) begin
                nb <= nb + {1'b0, nb != 2'h3};
                if (nb == 2'h0) begin
                    wr    <= hit && !sh[0];
                    rd    <= hit && sh[0];
                    quiet <= !hit;
                end else if ((rd && sda_i) || (wr && nb == 2'h3 && write_protect)) begin
                    quiet <= 1'b1;
                end
            end
        end
    end
    sequence stop_seen;
        sp_s[2] != sp_s[1];
    endsequence
    sequence bus_idle;
        !hs_mode && !bus_busy;
    endsequence
    slave_ack_a: assert property (@(posedge scl) disable iff (!rst_n)
        ack && nb == 2'h0 |-> sda_oe == hit) else $error("slave address answer wrong");
    addr_free_a: assert property (@(posedge scl) disable iff (!rst_n)
        nf || (nb == 2'h0 && cnt < 4'h8) |-> !sda_oe) else $error("driven during address");
    index_ack_a: assert property (@(posedge scl) disable iff (!rst_n)
        ack && wr && (nb == 2'h1 || nb == 2'h2) |-> sda_oe) else $error("address byte unacked");
    data_ack_a: assert property (@(posedge scl) disable iff (!rst_n)
        ack && wr && nb == 2'h3 && !quiet |-> sda_oe == !write_protect)
        else $error("data byte answer wrong");
    read_free_a: assert property (@(posedge scl) disable iff (!rst_n)
        ack && rd && nb != 2'h0 |-> !sda_oe) else $error("driven in master ack slot");
    quiet_bus_a: assert property (@(posedge scl) disable iff (!rst_n)
        quiet && !nf |-> !sda_oe) else $error("driven while not addressed");
    oe_stands_a: assert property (@(negedge scl) disable iff (!rst_n)
        sda_oe == oe_r) else $error("data changed while clock high");
    open_drain_a: assert property (@(posedge clk) disable iff (!rst_n)
        sda_o == 1'b0) else $error("data pin driven high");
    stop_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        stop_seen |-> ##[0:4] bus_idle) else $error("stop left mode or busy set");
endmodule
bind ism_slave ism_chk i_chk (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .device_select_pins(device_select_pins),
    .write_protect(write_protect), .hs_mode(hs_mode), .bus_busy(bus_busy));

// ===== tb/ism_mst.sv
module ism_mst (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock made here only; it stands high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // data set in the low phase, sampled mid-high, 30 ns slot
    task automatic bitx(input logic b, output logic r);
        sda_low = ~b;
        #7;
        scl = 1'b1;
        #8;
        r = sda;
        #7;
        scl = 1'b0;
        #8;
    endtask
    // byte msb first, then ninth clock; ack only when asked
    task automatic xfer(input logic [7:0] d, input logic m_ack,
                        output logic [7:0] q, output logic nine);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(~m_ack, nine);
    endtask
    // data falls with clock high, also as a repeated start
    task automatic start();
        sda_low = 1'b0;
        #7;
        scl = 1'b1;
        #8;
        sda_low = 1'b1;
        #8;
        scl = 1'b0;
        #7;
    endtask
    // data rises with clock high, then the bus rests
    task automatic stop();
        sda_low = 1'b1;
        #7;
        scl = 1'b1;
        #8;
        sda_low = 1'b0;
        #300;
    endtask
endmodule

// ===== tb/ism_slave_tb.sv
module ism_slave_tb
    import ism_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, wp = 1'b0, a, hs, busy;
    logic        scl, sda_low, sda_oe;
    logic [1:0]  sel = 2'h0;
    logic [7:0]  q;
    logic [7:0]  mm [int];
    logic [16:0] lat = 17'h00000;
    int          n_mismatch = 0, compares = 0;
    wire         sda = ~(sda_low | sda_oe); // pull-up wins when nobody pulls
    ism_slave i_dut (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe), .device_select_pins(sel), .write_protect(wp), .hs_mode(hs),
        .bus_busy(busy));
    ism_mst i_mst (.scl(scl), .sda_low(sda_low), .sda(sda));
    always #12.5 clk = ~clk;
    function automatic logic [16:0] nxt(logic [16:0] x);
        return (x == 17'h1ffff) ? 17'h00000 : x + 17'h00001;
    endfunction
    // comparisons for single flags and for bytes
    task automatic cmp1(logic g, logic e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic cmp8(logic [7:0] g, logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t byte %h expected %h", $time, g, e);
        end
    endtask
    task automatic tx(logic [7:0] d, logic e);
        i_mst.xfer(d, 1'b0, q, a);
        cmp1(~a, e);
    endtask
    // write header and index bytes, then n data bytes, kept in the model only while wp is low
    task automatic wr(logic [16:0] ad, int n);
        logic [7:0] d;
        i_mst.start();
        tx({DEV_TYPE, sel, ad[16], 1'b0}, 1'b1);
        tx(ad[15:8], 1'b1);
        tx(ad[7:0], 1'b1);
        lat = ad;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            tx(d, !wp);
            if (!wp) mm[lat] = d;
            if (!wp) lat = nxt(lat);
        end
    endtask
    // current address read of n bytes, last one left unacknowledged
    task automatic rd(int n);
        i_mst.start();
        tx({DEV_TYPE, sel, 1'b0, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            i_mst.xfer(8'hff, i < n - 1, q, a);
            cmp8(q, mm[lat]);
            lat = nxt(lat);
        end
        i_mst.stop();
    endtask
    task automatic finish_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog sized well above the sequence below
    initial begin
        #500000;
        n_mismatch++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end
    initial begin
        logic [16:0] ad;
        int          n;
        void'($urandom(32'h337ff1ed));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk) sel <= 2'($urandom);
        repeat (5) begin
            ad = 17'($urandom);
            n = 1 + $urandom % 4;
            wr(ad, n);
            i_mst.stop();
            wr(ad, 0);
            rd(n);
        end
        $display("test random done");
        wr(17'h1fffe, 3);
        i_mst.stop();
        wr(17'h1fffe, 0);
        rd(2);
        rd(1);
        $display("test wrap done");
        for (int i = 1; i >= 0; i--) wr({i[0], 16'habcd}, 1);
        i_mst.stop();
        wr(17'h0abcd, 0);
        rd(1);
        wr(17'h1abcd, 0);
        rd(1);
        $display("test page done");
        i_mst.start();
        tx({DEV_TYPE, ~sel, 2'h0}, 1'b0);
        tx(8'h00, 1'b0);
        i_mst.start();
        tx({4'h5, sel, 2'h0}, 1'b0);
        i_mst.stop();
        $display("test select done");
        @(posedge clk) wp <= 1'b1;
        wr(17'h0abcd, 1);
        i_mst.stop();
        @(posedge clk) wp <= 1'b0;
        rd(1);
        wr(17'h1abcd, 0);
        repeat (4) i_mst.bitx(1'b0, a);
        cmp1(busy, 1'b1);
        i_mst.stop();
        cmp1(busy, 1'b0);
        wr(17'h1abcd, 0);
        rd(1);
        $display("test abort done");
        i_mst.start();
        tx({HS_CODE, 3'h5}, 1'b0);
        repeat (8) @(posedge clk);
        cmp1(hs, 1'b1);
        wr(17'h00042, 2);
        wr(17'h00042, 0);
        rd(2);
        repeat (8) @(posedge clk);
        cmp1(hs, 1'b0);
        $display("test fast mode done");
        finish_test();
    end
endmodule
